// *** mrdp_pkg.sv ***
// package for the memory-reference datapath: widths, opcodes, state codes
// assumes a 12-bit word machine with 4096-word core
package mrdp_pkg;
  localparam int WORD_W = 12;
  localparam int OP_W = 3;
  localparam logic [2:0] OP_AND = 3'h0;
  localparam logic [2:0] OP_TWOS_COMPLEMENT_ADD = 3'h1;
  localparam logic [2:0] OP_INCREMENT_SKIP_IF_ZERO = 3'h2;
  localparam logic [2:0] OP_DEPOSIT_AND_CLEAR = 3'h3;
  localparam logic [2:0] OP_SUBROUTINE_CALL = 3'h4;
  localparam logic [2:0] OP_JUMP = 3'h5;
  localparam logic [2:0] OP_IOT = 3'h6;
  localparam logic [2:0] OP_OPERATE = 3'h7;
  localparam int IND_BIT = 8;
  localparam int PAGE_BIT = 7;
  localparam logic [11:0] START_PC = 12'h080;
  localparam logic [11:0] ZERO_WORD = 12'h000;
  localparam logic [11:0] ONE_WORD = 12'h001;
  // operate group 3 code and its transfer bits
  localparam logic [11:0] OPR3_MASK = 12'hf01;
  localparam logic [11:0] OPR3_CODE = 12'hf01;
  localparam int OPR3_CLA_BIT = 7;
  localparam int OPR3_MQA_BIT = 6;
  localparam int OPR3_MQL_BIT = 4;
  typedef enum logic [2:0] {
    MRDP_FETCH = 3'b000,
    MRDP_DECODE = 3'b001,
    MRDP_INDIR = 3'b011,
    MRDP_OPERAND = 3'b010,
    MRDP_EXEC = 3'b110,
    MRDP_WRITE = 3'b111,
    MRDP_HALT = 3'b101
  } mrdp_state_t;
endpackage

// *** mrdp_core_mem.sv ***
// core memory array with registered read data
// assumes a single clock; a write and read in one cycle use the old word
`timescale 1ns/1ns
`default_nettype none
module mrdp_core_mem #(
  parameter int DATA_W = 12,
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  output logic [DATA_W-1:0] rd_data
);
  initial begin
    if (DATA_W < 1 || ADDR_W < 1 || ADDR_W > 16) begin
      $error("mrdp_core_mem: unsupported size");
    end
  end
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
    rd_data <= mem[addr];
  end
endmodule // mrdp_core_mem
`default_nettype wire

// *** mrdp_datapath.sv ***
// memory-reference and accumulator instruction datapath
// assumes memory loaded through the load port while run is low
//
// Overview of operation
// - subroutine call writes return address (call address plus one) into operand word
// - subroutine call sets program counter to operand address plus one
// - indirect jump through subroutine's first word resumes caller
// - add places memory word plus accumulator into accumulator
// - carry out of top bit inverts link; no end-around carry
// - add leaves memory word unchanged
// - and replaces accumulator with accumulator and memory word
// - and pairs bits of equal index
// - and leaves link unchanged
// - and leaves memory word unchanged
// - increment-skip adds one; zero result skips next instruction
// - nonzero result continues with next instruction
// - incremented value always written back
// - increment-skip leaves accumulator unchanged
// - all ones wraps to zero and skips; all ones minus one does not
// - multiplier-quotient register: copy-and-clear accumulator, or into accumulator
// - deposit writes accumulator then clears it, link kept
// - jump loads effective address, accumulator and link kept
// - each fetch moves program counter to address register, then increments
`timescale 1ns/1ns
`default_nettype none
module mrdp_datapath
  import mrdp_pkg::*;
#(
  parameter int DATA_W = WORD_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic load_en,
  input wire logic [11:0] load_addr,
  input wire logic [11:0] load_data,
  output logic [11:0] accumulator,
  output logic link,
  output logic [11:0] program_counter,
  output logic [11:0] multiplier_quotient_register,
  output logic [11:0] mem_addr,
  output logic [11:0] memory_buffer,
  output logic halted,
  output logic instr_done
);
  initial begin
    if (DATA_W != WORD_W) begin
      $error("mrdp_datapath: word width must be twelve");
    end
  end

  typedef struct packed {
    mrdp_state_t st;
    logic [11:0] acc;
    logic lnk;
    logic [11:0] pc;
    logic [11:0] mq;
    logic [11:0] ma;
    logic [11:0] ir;
    logic [11:0] mb;
    logic done;
  } mrdp_regs_t;

  mrdp_regs_t q_r;
  mrdp_regs_t q_nxt;
  logic mem_we;
  logic [11:0] mem_wdata;
  logic [11:0] mem_rdata;
  logic [12:0] sum;
  logic [11:0] inc_val;

  // direct address: page zero or current page of the instruction
  function automatic logic [11:0] direct_addr(input logic [11:0] ir, input logic [11:0] ia);
    direct_addr = ir[PAGE_BIT] ? {ia[11:7], ir[6:0]} : {5'h00, ir[6:0]};
  endfunction

  function automatic logic is_mem_ref(input logic [11:0] ir);
    is_mem_ref = ir[11:9] < OP_IOT;
  endfunction

  mrdp_core_mem #(
    .DATA_W(12),
    .ADDR_W(12)
  ) u_mem (
    .ref_clk(ref_clk),
    .wr_en(mem_we),
    // next address so the registered read word lines up with the next state
    .addr(load_en ? load_addr : q_nxt.ma),
    .wr_data(load_en ? load_data : mem_wdata),
    .rd_data(mem_rdata)
  );

  assign sum = {1'b0, q_r.acc} + {1'b0, mem_rdata};
  assign inc_val = mem_rdata + ONE_WORD;

  always_comb begin
    q_nxt = q_r;
    q_nxt.done = 1'b0;
    mem_we = load_en;
    mem_wdata = ZERO_WORD;
    if (!load_en) begin
      unique case (q_r.st)
        MRDP_FETCH: begin
          if (run) begin
            q_nxt.ma = q_r.pc;
            q_nxt.pc = q_r.pc + ONE_WORD;
            q_nxt.st = MRDP_DECODE;
          end
        end
        MRDP_DECODE: begin
          // instruction word is on the read port now
          q_nxt.ir = mem_rdata;
          q_nxt.mb = mem_rdata;
          if (is_mem_ref(mem_rdata)) begin
            q_nxt.ma = direct_addr(mem_rdata, q_r.ma);
            if (mem_rdata[IND_BIT]) begin
              q_nxt.st = MRDP_INDIR;
            end else if (mem_rdata[11:9] == OP_JUMP || mem_rdata[11:9] == OP_SUBROUTINE_CALL
                         || mem_rdata[11:9] == OP_DEPOSIT_AND_CLEAR) begin
              q_nxt.st = MRDP_EXEC;
            end else begin
              q_nxt.st = MRDP_OPERAND;
            end
          end else begin
            if ((mem_rdata & OPR3_MASK) == OPR3_CODE) begin
              // clear, then or in, then load: both transfers with clear set swap
              q_nxt.acc = mem_rdata[OPR3_CLA_BIT] ? ZERO_WORD : q_r.acc;
              if (mem_rdata[OPR3_MQA_BIT]) begin
                q_nxt.acc = q_nxt.acc | q_r.mq;
              end
              if (mem_rdata[OPR3_MQL_BIT]) begin
                q_nxt.mq = q_r.acc;
                q_nxt.acc = mem_rdata[OPR3_MQA_BIT] ? q_nxt.acc : ZERO_WORD;
              end
              q_nxt.st = MRDP_FETCH;
              q_nxt.done = 1'b1;
            end else begin
              q_nxt.st = MRDP_HALT;
            end
          end
        end
        MRDP_INDIR: begin
          // wait one cycle for the pointer read
          q_nxt.st = MRDP_OPERAND;
        end
        MRDP_OPERAND: begin
          if (q_r.ir[IND_BIT] && q_r.mb == q_r.ir) begin
            q_nxt.ma = mem_rdata;
            q_nxt.mb = ZERO_WORD;
            if (q_r.ir[11:9] == OP_JUMP || q_r.ir[11:9] == OP_SUBROUTINE_CALL
                || q_r.ir[11:9] == OP_DEPOSIT_AND_CLEAR) begin
              q_nxt.st = MRDP_EXEC;
            end else begin
              q_nxt.st = MRDP_WRITE;
            end
          end else begin
            q_nxt.st = MRDP_EXEC;
          end
        end
        MRDP_WRITE: begin
          // operand read wait after an indirect pointer
          q_nxt.st = MRDP_EXEC;
        end
        MRDP_EXEC: begin
          q_nxt.st = MRDP_FETCH;
          q_nxt.done = 1'b1;
          unique case (q_r.ir[11:9])
            OP_AND: begin
              q_nxt.acc = q_r.acc & mem_rdata;
              q_nxt.mb = mem_rdata;
            end
            OP_TWOS_COMPLEMENT_ADD: begin
              q_nxt.acc = sum[11:0];
              q_nxt.lnk = q_r.lnk ^ sum[12];
              q_nxt.mb = mem_rdata;
            end
            OP_INCREMENT_SKIP_IF_ZERO: begin
              mem_we = 1'b1;
              mem_wdata = inc_val;
              q_nxt.mb = inc_val;
              if (inc_val == ZERO_WORD) begin
                q_nxt.pc = q_r.pc + ONE_WORD;
              end
            end
            OP_DEPOSIT_AND_CLEAR: begin
              mem_we = 1'b1;
              mem_wdata = q_r.acc;
              q_nxt.mb = q_r.acc;
              q_nxt.acc = ZERO_WORD;
            end
            OP_SUBROUTINE_CALL: begin
              mem_we = 1'b1;
              mem_wdata = q_r.pc;
              q_nxt.mb = q_r.pc;
              q_nxt.pc = q_r.ma + ONE_WORD;
            end
            OP_JUMP: begin
              q_nxt.pc = q_r.ma;
            end
            default: begin
              q_nxt.st = MRDP_HALT;
            end
          endcase
        end
        MRDP_HALT: begin
          if (!run) begin
            q_nxt.st = MRDP_FETCH;
          end
        end
        default: begin
          q_nxt.st = MRDP_FETCH;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q_r <= '{st: MRDP_FETCH, acc: ZERO_WORD, lnk: 1'b0, pc: START_PC, mq: ZERO_WORD,
               ma: ZERO_WORD, ir: ZERO_WORD, mb: ZERO_WORD, done: 1'b0};
    end else begin
      q_r <= q_nxt;
    end
  end

  assign accumulator = q_r.acc;
  assign link = q_r.lnk;
  assign program_counter = q_r.pc;
  assign multiplier_quotient_register = q_r.mq;
  assign mem_addr = q_r.ma;
  assign memory_buffer = q_r.mb;
  assign halted = q_r.st == MRDP_HALT;
  assign instr_done = q_r.done;
endmodule // mrdp_datapath
`default_nettype wire

// *** mrdp_monitor.sv ***
// checker on the datapath top-level ports
// bound onto mrdp_datapath from the testbench top file
`timescale 1ns/1ns
`default_nettype none
module mrdp_monitor
  import mrdp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic run,
  input wire logic load_en,
  input wire logic [11:0] accumulator,
  input wire logic link,
  input wire logic [11:0] program_counter,
  input wire logic [11:0] multiplier_quotient_register,
  input wire logic [11:0] mem_addr,
  input wire logic halted,
  input wire logic instr_done
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_acc_end; $changed(accumulator) |-> instr_done; endproperty
  a_acc_end: assert property (p_acc_end) else $error("acc moved mid-instruction");
  property p_link_end; $changed(link) |-> instr_done; endproperty
  a_link_end: assert property (p_link_end) else $error("link moved mid-instruction");
  property p_mq_end; $changed(multiplier_quotient_register) |-> instr_done; endproperty
  a_mq_end: assert property (p_mq_end) else $error("mq moved mid-instruction");
  property p_fetch;
    instr_done && run && !load_en |=> mem_addr == $past(program_counter) &&
      program_counter == $past(program_counter) + 12'h001;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch did not step pc");
  property p_done_pulse; instr_done |=> !instr_done; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done wider than one cycle");
  property p_halt_holds; halted && run |=> halted ##1 halted; endproperty
  a_halt_holds: assert property (p_halt_holds) else $error("halt dropped");
  property p_halt_quiet; halted |-> !instr_done && $stable(accumulator); endproperty
  a_halt_quiet: assert property (p_halt_quiet) else $error("activity while halted");
  property p_load_stall; load_en |=> $stable(program_counter); endproperty
  a_load_stall: assert property (p_load_stall) else $error("core ran during load");
endmodule // mrdp_monitor
`default_nettype wire

// *** mrdp_mem_loader.sv ***
// core memory image model: writes the test program through the load port
// assumes the bench holds run low until done rises
`timescale 1ns/1ns
`default_nettype none
module mrdp_mem_loader (
  input wire logic ref_clk,
  input wire logic start,
  output logic load_en,
  output logic [11:0] load_addr,
  output logic [11:0] load_data,
  output logic done
);
  localparam int N = 24;
  // {address, word}; page-zero data at 0x040, call target at 0x050
  localparam logic [23:0] IMG [N] = '{
    24'h080241, 24'h081240, 24'h082244, 24'h083043, 24'h084442, 24'h085442,
    24'h086c00, 24'h087850, 24'h088645, 24'h089242, 24'h08a245, 24'h08bf11,
    24'h08c241, 24'h08df41, 24'h08ea91, 24'h08fc00, 24'h091c00, 24'h051243,
    24'h052b50, 24'h040fff, 24'h041001, 24'h042ffe, 24'h0430f0, 24'h0443c3};
  initial begin
    load_en = 1'b0;
    {load_addr, load_data} = 24'h000000;
    done = 1'b0;
    wait (start);
    for (int i = 0; i < N; i++) begin
      @(negedge ref_clk);
      load_en = 1'b1;
      {load_addr, load_data} = IMG[i];
    end
    @(negedge ref_clk);
    load_en = 1'b0;
    {load_addr, load_data} = 24'hffffff;
    done = 1'b1;
  end
endmodule // mrdp_mem_loader
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench: loads a program, checks each instruction's result
// assumes inputs change at falling edges, outputs sampled there
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import mrdp_pkg::*;
  logic ref_clk, rst, run, start, load_en, link, halted, instr_done, done;
  logic [11:0] load_addr, load_data, acc, pc, mq, ma, mb;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  // {acc, pc} after each executed instruction
  localparam logic [23:0] EXP [16] = '{
    24'h001081, 24'h000082, 24'h3c3083, 24'h0c0084, 24'h0c0085, 24'h0c0087,
    24'h0c0051, 24'h1b0052, 24'h1b0088, 24'h000089, 24'h00008a, 24'h1b008b,
    24'h00008c, 24'h00108d, 24'h1b108e, 24'h1b1091};
  mrdp_datapath u_dut (.ref_clk(ref_clk), .rst(rst), .run(run), .load_en(load_en),
    .load_addr(load_addr), .load_data(load_data), .accumulator(acc), .link(link),
    .program_counter(pc), .multiplier_quotient_register(mq), .mem_addr(ma),
    .memory_buffer(mb), .halted(halted), .instr_done(instr_done));
  mrdp_mem_loader u_mem (.ref_clk(ref_clk), .start(start), .load_en(load_en),
    .load_addr(load_addr), .load_data(load_data), .done(done));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      conclude();
    end
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic t_reset();
    chk(acc, ZERO_WORD, "reset acc");
    chk(pc, START_PC, "reset pc");
    chk(mq, ZERO_WORD, "reset mq");
    chk({11'h000, halted}, 12'h000, "reset halt");
  endtask
  task automatic t_run();
    int k;
    @(negedge ref_clk);
    run = 1'b1;
    for (int i = 0; i < 16; i++) begin
      k = 0;
      do begin
        @(negedge ref_clk);
        k++;
      end while (instr_done !== 1'b1 && k < 50);
      chk(acc, EXP[i][23:12], "step acc");
      chk(pc, EXP[i][11:0], "step pc");
      chk({11'h000, link}, {11'h000, i > 0}, "step link");
    end
  endtask
  task automatic t_final();
    int k;
    k = 0;
    while (halted !== 1'b1 && k < 20) begin
      @(negedge ref_clk);
      k++;
    end
    chk({11'h000, halted}, 12'h001, "halt");
    chk(pc, 12'h092, "final pc");
    chk(mq, 12'h1b0, "final mq");
    chk(acc, 12'h1b1, "final acc");
  endtask
  task automatic conclude();
    if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    run = 1'b0;
    start = 1'b0;
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    t_reset();
    start = 1'b1;
    wait (done);
    t_run();
    t_final();
    conclude();
  end
endmodule // tb_top
bind mrdp_datapath mrdp_monitor u_mon (.ref_clk(ref_clk), .rst(rst), .run(run),
  .load_en(load_en), .accumulator(accumulator), .link(link),
  .program_counter(program_counter), .mem_addr(mem_addr), .halted(halted),
  .multiplier_quotient_register(multiplier_quotient_register), .instr_done(instr_done));
`default_nettype wire
